/* File: jsd_pkg.sv */
package jsd_pkg;

	// chain population, fixed for this device
	localparam int NUM_IOB = 4;
	localparam int NUM_IN_ONLY = 1;
	localparam int NUM_OUT_ONLY = 1;
	localparam int NUM_CLK_PIN = 4;
	localparam int CHAIN_LEN = 2 + 3 * NUM_IOB + NUM_IN_ONLY + NUM_OUT_ONLY + 1;

	// chain bit positions, bit 0 sits next to the scan output
	localparam int BIT_TDO_EN = 0;
	localparam int BIT_TDO_DATA = 1;
	localparam int BIT_IOB_BASE = 2;
	localparam int BIT_IN_ONLY = BIT_IOB_BASE + 3 * NUM_IOB;
	localparam int BIT_OUT_ONLY = BIT_IN_ONLY + NUM_IN_ONLY;
	localparam int BIT_UPD = CHAIN_LEN - 1;

	// cell offsets inside one io block
	localparam int OFS_OE = 0;
	localparam int OFS_OUT = 1;
	localparam int OFS_IN = 2;

	// io blocks that carry the tap inputs
	localparam int IOB_TMS = 0;
	localparam int IOB_TCK = 1;
	localparam int IOB_TDI = 2;

	// apb register map
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_BSR = 12'h008;
	localparam int CTRL_KEEP_BIT = 0;
	localparam logic CTRL_KEEP_RST = 1'b0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_INSTR_LSB = 4;
	localparam int STAT_CONFIG_BIT = 8;
	localparam int STAT_ACTIVE_BIT = 9;

	localparam logic [2:0] IR_CAPTURE = 3'h1;

	typedef enum logic [2:0] {
		INS_EXTEST = 3'b000,
		INS_SAMPLE = 3'b001,
		INS_USER_SCAN_INSTR_ONE = 3'b010,
		INS_USER_SCAN_INSTR_TWO = 3'b011,
		INS_READBACK = 3'b100,
		INS_CONFIGURE = 3'b101,
		INS_RESERVED = 3'b110,
		INS_BYPASS = 3'b111
	} jsd_instr_e;

	localparam jsd_instr_e IR_RESET = INS_BYPASS;

	typedef enum logic [3:0] {
		TS_EXIT2_DR = 4'b0000,
		TS_EXIT1_DR = 4'b0001,
		TS_SHIFT_DR = 4'b0010,
		TS_PAUSE_DR = 4'b0011,
		TS_SEL_IR = 4'b0100,
		TS_UPDATE_DR = 4'b0101,
		TS_CAPTURE_DR = 4'b0110,
		TS_SEL_DR = 4'b0111,
		TS_EXIT2_IR = 4'b1000,
		TS_EXIT1_IR = 4'b1001,
		TS_SHIFT_IR = 4'b1010,
		TS_PAUSE_IR = 4'b1011,
		TS_IDLE = 4'b1100,
		TS_UPDATE_IR = 4'b1101,
		TS_CAPTURE_IR = 4'b1110,
		TS_RESET = 4'b1111
	} jsd_tap_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jsd_tap_pins_s;

	typedef struct packed {
		logic reset;
		logic update;
		logic shift;
	} jsd_user_state_s;

endpackage : jsd_pkg

/* File: jsd_sync.sv */
`timescale 1ns/10ps
module jsd_sync import jsd_pkg::*; #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	// first stage is read by the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : jsd_sync

/* File: jsd_tap.sv */
`timescale 1ns/10ps
module jsd_tap import jsd_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tck_rise,
	input wire logic tms,
	input wire logic force_reset,
	output jsd_tap_e state_r
);

	jsd_tap_e state_nxt;

	always_comb begin
		case (state_r)
			TS_RESET: state_nxt = tms ? TS_RESET : TS_IDLE;
			TS_IDLE: state_nxt = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_DR: state_nxt = tms ? TS_SEL_IR : TS_CAPTURE_DR;
			TS_CAPTURE_DR: state_nxt = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_SHIFT_DR: state_nxt = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
			TS_EXIT1_DR: state_nxt = tms ? TS_UPDATE_DR : TS_PAUSE_DR;
			TS_PAUSE_DR: state_nxt = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
			TS_EXIT2_DR: state_nxt = tms ? TS_UPDATE_DR : TS_SHIFT_DR;
			TS_UPDATE_DR: state_nxt = tms ? TS_SEL_DR : TS_IDLE;
			TS_SEL_IR: state_nxt = tms ? TS_RESET : TS_CAPTURE_IR;
			TS_CAPTURE_IR: state_nxt = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_SHIFT_IR: state_nxt = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
			TS_EXIT1_IR: state_nxt = tms ? TS_UPDATE_IR : TS_PAUSE_IR;
			TS_PAUSE_IR: state_nxt = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
			TS_EXIT2_IR: state_nxt = tms ? TS_UPDATE_IR : TS_SHIFT_IR;
			TS_UPDATE_IR: state_nxt = tms ? TS_SEL_DR : TS_IDLE;
			default: state_nxt = TS_RESET;
		endcase
	end

	// no test reset pin: reset comes from presetn, tms held high, or scan released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= TS_RESET;
		end else if (force_reset) begin
			state_r <= TS_RESET;
		end else if (tck_rise) begin
			state_r <= state_nxt;
		end
	end

endmodule : jsd_tap

/* File: jsd_top.sv */
`timescale 1ns/10ps
module jsd_top import jsd_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire jsd_tap_pins_s tap_pins,
	output logic tdo_out,
	output logic tdo_oe_n,
	input wire logic config_done,
	input wire logic readback_data,
	input wire logic config_dout,
	input wire logic [NUM_IOB-1:0] io_in,
	output logic [NUM_IOB-1:0] io_out,
	output logic [NUM_IOB-1:0] io_oe_n,
	input wire logic [NUM_IN_ONLY-1:0] in_only_pin,
	input wire logic [NUM_OUT_ONLY-1:0] core_out_only,
	output logic [NUM_OUT_ONLY-1:0] out_only_pin,
	output logic pin_pull_up,
	input wire logic [NUM_IOB-1:0] core_out,
	input wire logic [NUM_IOB-1:0] core_oe,
	output logic [NUM_IOB-1:0] core_in,
	output logic [NUM_IN_ONLY-1:0] core_in_only,
	input wire logic [NUM_CLK_PIN-1:0] primary_clock_inputs,
	output logic [NUM_CLK_PIN-1:0] clock_net,
	output logic user_select_one,
	output logic user_select_two,
	input wire logic user_scan_out_one,
	input wire logic user_scan_out_two,
	output logic user_datareg_clock,
	output logic user_idle_strobe,
	output jsd_user_state_s user_state,
	output logic user_tdi
);

	jsd_tap_pins_s tap_s;
	logic [NUM_IOB-1:0] io_in_s;
	logic [NUM_IN_ONLY-1:0] in_only_s;
	logic [NUM_CLK_PIN-1:0] clk_pin_s;
	logic tck_d_r;
	logic tck_rise;
	logic tck_fall;
	jsd_tap_e tap_state;
	jsd_instr_e instr_r;
	logic [2:0] ir_shift_r;
	logic [CHAIN_LEN-1:0] bsr_shift_r;
	logic [CHAIN_LEN-1:0] bsr_upd_r;
	logic [CHAIN_LEN-1:0] capture_vec;
	logic bypass_r;
	logic scan_keep_r;
	logic scan_active;
	logic bsr_selected;
	logic extest_on;
	logic cfg_load_on;
	logic tdo_src;
	logic [NUM_IOB-1:0] drive_en;
	logic [NUM_IOB-1:0] drive_val;
	logic [31:0] rd_nxt;
	logic addr_ok;

	// every tap, io, input-only and clock pin passes two flops before any logic looks at it; the done pin is used unsynchronised
	jsd_sync #(.W(3)) u_sync_tap (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tap_pins),
		.sync_out(tap_s)
	);

	jsd_sync #(.W(NUM_IOB + NUM_IN_ONLY + NUM_CLK_PIN)) u_sync_pins (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({primary_clock_inputs, in_only_pin, io_in}),
		.sync_out({clk_pin_s, in_only_s, io_in_s})
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_d_r <= 1'b0;
		end else begin
			tck_d_r <= tap_s.tck;
		end
	end

	assign tck_rise = tap_s.tck & ~tck_d_r;
	assign tck_fall = ~tap_s.tck & tck_d_r;

	// scan stays alive after configuration only when software keeps it
	assign scan_active = ~config_done | scan_keep_r;

	// tap state comes from the pin, never from chain contents
	jsd_tap u_tap (
		.pclk(pclk),
		.presetn(presetn),
		.tck_rise(tck_rise),
		.tms(tap_s.tms),
		.force_reset(~scan_active),
		.state_r(tap_state)
	);

	assign bsr_selected = (instr_r == INS_EXTEST) | (instr_r == INS_SAMPLE);
	assign extest_on = scan_active & (instr_r == INS_EXTEST);
	assign cfg_load_on = scan_active & (instr_r == INS_CONFIGURE);

	// capture picture of the ring; chain index follows the edge walk
	// top edge right to left, left, bottom, right edge bottom to top
	always_comb begin
		capture_vec = '0;
		capture_vec[BIT_TDO_EN] = ~tdo_oe_n;
		capture_vec[BIT_TDO_DATA] = tdo_out;
		for (int i = 0; i < NUM_IOB; i++) begin
			capture_vec[BIT_IOB_BASE + 3 * i + OFS_OE] = drive_en[i];
			capture_vec[BIT_IOB_BASE + 3 * i + OFS_OUT] = drive_val[i];
			capture_vec[BIT_IOB_BASE + 3 * i + OFS_IN] = io_in_s[i];
		end
		for (int i = 0; i < NUM_IN_ONLY; i++) begin
			capture_vec[BIT_IN_ONLY + i] = in_only_s[i];
		end
		for (int i = 0; i < NUM_OUT_ONLY; i++) begin
			capture_vec[BIT_OUT_ONLY + i] = core_out_only[i];
		end
		// config clear, clock and done pins own no cell at all
		capture_vec[BIT_UPD] = 1'b0;
	end

	// instruction register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_shift_r <= 3'h0;
			instr_r <= IR_RESET;
		end else if (!scan_active || tap_state == TS_RESET) begin
			ir_shift_r <= 3'h0;
			instr_r <= IR_RESET;
		end else if (tck_rise) begin
			case (tap_state)
				TS_CAPTURE_IR: ir_shift_r <= IR_CAPTURE;
				TS_SHIFT_IR: ir_shift_r <= {tap_s.tdi, ir_shift_r[2:1]};
				TS_UPDATE_IR: instr_r <= jsd_instr_e'(ir_shift_r);
				default: ir_shift_r <= ir_shift_r;
			endcase
		end
	end

	// boundary register, shifting toward bit 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsr_shift_r <= '0;
		end else if (tck_rise && bsr_selected) begin
			if (tap_state == TS_CAPTURE_DR) begin
				bsr_shift_r <= capture_vec;
			end else if (tap_state == TS_SHIFT_DR) begin
				bsr_shift_r <= {tap_s.tdi, bsr_shift_r[CHAIN_LEN-1:1]};
			end
		end
	end

	// update stage holds what extest drives; sample preloads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bsr_upd_r <= '0;
		end else if (tck_rise && bsr_selected && tap_state == TS_UPDATE_DR) begin
			bsr_upd_r <= bsr_shift_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bypass_r <= 1'b0;
		end else if (tck_rise) begin
			if (tap_state == TS_CAPTURE_DR) begin
				bypass_r <= 1'b0;
			end else if (tap_state == TS_SHIFT_DR) begin
				bypass_r <= tap_s.tdi;
			end
		end
	end

	always_comb begin
		if (tap_state == TS_SHIFT_IR) begin
			tdo_src = ir_shift_r[0];
		end else begin
			case (instr_r)
				INS_EXTEST: tdo_src = bsr_shift_r[0];
				INS_SAMPLE: tdo_src = bsr_shift_r[0];
				INS_USER_SCAN_INSTR_ONE: tdo_src = user_scan_out_one;
				INS_USER_SCAN_INSTR_TWO: tdo_src = user_scan_out_two;
				INS_READBACK: tdo_src = readback_data;
				INS_CONFIGURE: tdo_src = config_dout;
				INS_BYPASS: tdo_src = bypass_r;
				default: tdo_src = bypass_r;
			endcase
		end
	end

	// tdo changes on the falling tck edge, driven only while shifting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdo_out <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (!scan_active) begin
			tdo_out <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo_out <= tdo_src;
			tdo_oe_n <= ~((tap_state == TS_SHIFT_DR) | (tap_state == TS_SHIFT_IR));
		end
	end

	// pin drive per io block
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IOB; gi++) begin : g_iob
			logic tap_pin;
			assign tap_pin = (gi == IOB_TMS) | (gi == IOB_TCK) | (gi == IOB_TDI);
			always_comb begin
				if (!config_done) begin
					drive_en[gi] = 1'b0;
				end else if (extest_on) begin
					drive_en[gi] = bsr_upd_r[BIT_IOB_BASE + 3 * gi + OFS_OE];
				end else if (cfg_load_on) begin
					drive_en[gi] = 1'b0;
				end else begin
					drive_en[gi] = core_oe[gi];
				end
				if (extest_on) begin
					drive_val[gi] = bsr_upd_r[BIT_IOB_BASE + 3 * gi + OFS_OUT];
				end else begin
					drive_val[gi] = core_out[gi];
				end
			end
			// or-gate keeps tap pins from fighting their own inputs
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					io_oe_n[gi] <= 1'b1;
					io_out[gi] <= 1'b0;
				end else begin
					io_oe_n[gi] <= ~drive_en[gi] | (tap_pin & scan_active);
					io_out[gi] <= drive_val[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_only_pin <= '0;
			core_in <= '0;
			core_in_only <= '0;
			pin_pull_up <= 1'b1;
			clock_net <= '0;
		end else begin
			for (int i = 0; i < NUM_OUT_ONLY; i++) begin
				out_only_pin[i] <= extest_on ? bsr_upd_r[BIT_OUT_ONLY + i] : core_out_only[i];
			end
			core_in <= io_in_s;
			core_in_only <= in_only_s;
			pin_pull_up <= ~config_done;
			// clock nets follow their pads; a pad driver in extest still reaches them
			clock_net <= clk_pin_s;
		end
	end

	// user scan hooks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_select_one <= 1'b0;
			user_select_two <= 1'b0;
			user_datareg_clock <= 1'b1;
			user_idle_strobe <= 1'b1;
			user_state <= '0;
			user_tdi <= 1'b0;
		end else begin
			user_select_one <= scan_active & (instr_r == INS_USER_SCAN_INSTR_ONE);
			user_select_two <= scan_active & (instr_r == INS_USER_SCAN_INSTR_TWO);
			// gated tck: runs only in capture and shift of a user register
			if ((instr_r == INS_USER_SCAN_INSTR_ONE || instr_r == INS_USER_SCAN_INSTR_TWO) &&
				(tap_state == TS_CAPTURE_DR || tap_state == TS_SHIFT_DR)) begin
				user_datareg_clock <= tap_s.tck;
			end else begin
				user_datareg_clock <= 1'b1;
			end
			user_idle_strobe <= ~(tap_s.tck & (tap_state == TS_IDLE));
			user_state.reset <= (tap_state == TS_RESET);
			user_state.update <= (tap_state == TS_UPDATE_DR);
			user_state.shift <= (tap_state == TS_SHIFT_DR);
			user_tdi <= tap_s.tdi;
		end
	end

	// apb slave, zero wait states
	always_comb begin
		addr_ok = 1'b1;
		rd_nxt = 32'h0;
		case (paddr)
			ADDR_CTRL: rd_nxt[CTRL_KEEP_BIT] = scan_keep_r;
			ADDR_STATUS: begin
				rd_nxt[STAT_STATE_LSB +: 4] = tap_state;
				rd_nxt[STAT_INSTR_LSB +: 3] = instr_r;
				rd_nxt[STAT_CONFIG_BIT] = config_done;
				rd_nxt[STAT_ACTIVE_BIT] = scan_active;
			end
			ADDR_BSR: rd_nxt[CHAIN_LEN-1:0] = bsr_upd_r;
			default: addr_ok = 1'b0;
		endcase
	end

	assign pready = psel & penable;
	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0 : rd_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_keep_r <= CTRL_KEEP_RST;
		end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
			scan_keep_r <= pwdata[CTRL_KEEP_BIT];
		end
	end

endmodule : jsd_top

/* File: jsd_chk.sv */
`timescale 1ns/10ps
module jsd_chk import jsd_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic config_done,
	input wire logic [NUM_IOB-1:0] io_in,
	input wire logic [NUM_IOB-1:0] io_oe_n,
	input wire logic pin_pull_up,
	input wire logic [NUM_IOB-1:0] core_in,
	input wire logic [NUM_IN_ONLY-1:0] in_only_pin,
	input wire logic [NUM_IN_ONLY-1:0] core_in_only,
	input wire jsd_tap_pins_s tap_pins,
	input wire logic user_tdi,
	input wire logic [NUM_CLK_PIN-1:0] primary_clock_inputs,
	input wire logic [NUM_CLK_PIN-1:0] clock_net,
	input wire logic user_select_one,
	input wire logic user_select_two,
	input wire logic user_datareg_clock,
	input wire logic user_idle_strobe,
	input wire jsd_user_state_s user_state
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_sel_exclusive: assert property (!(user_select_one && user_select_two))
		else $error("both user selects high");
	a_tap_oe_off: assert property ((user_select_one || user_select_two) |->
		io_oe_n[IOB_TMS] && io_oe_n[IOB_TCK] && io_oe_n[IOB_TDI]) else $error("tap pin driven");
	a_precfg_float: assert property (!config_done [*3] |-> &io_oe_n && pin_pull_up)
		else $error("output driven before config");
	a_state_onehot: assert property ($onehot0(user_state))
		else $error("user state decodes overlap");
	a_idle_nand: assert property (!user_idle_strobe |-> user_state == '0)
		else $error("idle strobe outside idle");
	a_drck_user: assert property (!user_datareg_clock |-> user_select_one || user_select_two)
		else $error("data register clock without user instruction");
	a_clock_direct: assert property ($stable(primary_clock_inputs) [*6] |->
		clock_net == primary_clock_inputs) else $error("clock net not from pin");
	a_core_in_pins: assert property ($stable(io_in) [*6] |-> core_in == io_in)
		else $error("core input not from pin");
	a_err_unmapped: assert property (psel && penable && paddr > ADDR_BSR |-> pready && pslverr)
		else $error("unmapped access without error");
	a_in_only_pin: assert property ($stable(in_only_pin) [*6] |-> core_in_only == in_only_pin)
		else $error("input-only pin not passed to core");
	a_tdi_user: assert property ($stable(tap_pins.tdi) [*6] |-> user_tdi == tap_pins.tdi)
		else $error("user tdi not from pin");
	c_sel_one: cover property (user_select_one);
	c_sel_two: cover property (user_select_two);
	c_drck: cover property ($fell(user_datareg_clock));
	c_unmapped: cover property (pslverr);
	c_idle: cover property (!user_idle_strobe);
endmodule : jsd_chk

bind jsd_top jsd_chk i_jsd_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.config_done(config_done), .io_in(io_in), .io_oe_n(io_oe_n), .pin_pull_up(pin_pull_up),
	.core_in(core_in), .in_only_pin(in_only_pin), .core_in_only(core_in_only),
	.tap_pins(tap_pins), .user_tdi(user_tdi),
	.primary_clock_inputs(primary_clock_inputs), .clock_net(clock_net),
	.user_select_one(user_select_one), .user_select_two(user_select_two),
	.user_datareg_clock(user_datareg_clock), .user_idle_strobe(user_idle_strobe),
	.user_state(user_state));

/* File: jsd_jtag_host.sv */
`timescale 1ns/10ps
module jsd_jtag_host import jsd_pkg::*; (
	output jsd_tap_pins_s tap_pins,
	input wire logic tdo_out,
	input wire logic tdo_oe_n
);
	// tck stands still between frames and tms rests high
	initial tap_pins = 3'b010;
	// pins move by non-blocking assignment so a coincident pclk edge sees the old value
	task automatic run(input logic [31:0] tms_v, input logic [31:0] tdi_v, input int n,
		output logic [31:0] tdo_v);
		logic last;
		last = 1'b0;
		tdo_v = '0;
		for (int i = 0; i < n; i++) begin
			tap_pins.tms <= tms_v[i];
			tap_pins.tdi <= tdi_v[i];
			#32;
			// released tdo has no pull: show the inverse of its last driven bit
			if (!tdo_oe_n) begin
				last = tdo_out;
			end
			tdo_v[i] = tdo_oe_n ? ~last : tdo_out;
			tap_pins.tck <= 1'b1;
			#32;
			tap_pins.tck <= 1'b0;
		end
		// undriven tdi has no pull, show the inverse of the last bit
		tap_pins.tdi <= ~tap_pins.tdi;
		tap_pins.tms <= 1'b1;
		// idle gap so the next frame never retouches tms in this time step
		#32;
	endtask : run
	task automatic tap_reset;
		logic [31:0] q;
		run(32'h1f, 32'h0, 6, q);
	endtask : tap_reset
	task automatic load_ir(input logic [2:0] ins, output logic [2:0] cap);
		logic [31:0] q;
		run(32'h0c3, {25'h0, ins, 4'h0}, 9, q);
		cap = q[6:4];
	endtask : load_ir
	task automatic scan_dr(input logic [31:0] d, input int n, output logic [31:0] q);
		run(32'h1 | (32'h3 << (n + 2)), d << 3, n + 5, q);
		q = (q >> 3) & ((32'h1 << n) - 32'h1);
	endtask : scan_dr
endmodule : jsd_jtag_host

/* File: jsd_top_tb_top.sv */
`timescale 1ns/10ps
module jsd_top_tb_top import jsd_pkg::*;;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q, d, p;
	logic pready, pslverr, tdo_out, tdo_oe_n, pin_pull_up, err, user_tdi;
	logic config_done = 1'b0, readback_data = 1'b0, config_dout = 1'b0;
	logic [NUM_IOB-1:0] io_in = '0, core_out = '0, core_oe = '0, io_out, io_oe_n, core_in;
	logic [NUM_IN_ONLY-1:0] in_only_pin = '0, core_in_only;
	logic [NUM_OUT_ONLY-1:0] core_out_only = '0, out_only_pin;
	logic [NUM_CLK_PIN-1:0] primary_clock_inputs = '0, clock_net;
	logic user_scan_out_one = 1'b0, user_scan_out_two = 1'b0;
	logic user_select_one, user_select_two, user_datareg_clock, user_idle_strobe;
	logic [2:0] cap;
	jsd_tap_pins_s tap_pins;
	jsd_user_state_s user_state;
	int failures = 0, comparisons = 0;

	jsd_top i_jsd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tap_pins(tap_pins), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
		.config_done(config_done), .readback_data(readback_data), .config_dout(config_dout),
		.io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .in_only_pin(in_only_pin),
		.core_out_only(core_out_only), .out_only_pin(out_only_pin), .pin_pull_up(pin_pull_up),
		.core_out(core_out), .core_oe(core_oe), .core_in(core_in), .core_in_only(core_in_only),
		.primary_clock_inputs(primary_clock_inputs), .clock_net(clock_net),
		.user_select_one(user_select_one), .user_select_two(user_select_two),
		.user_scan_out_one(user_scan_out_one), .user_scan_out_two(user_scan_out_two),
		.user_datareg_clock(user_datareg_clock), .user_idle_strobe(user_idle_strobe),
		.user_state(user_state), .user_tdi(user_tdi));
	jsd_jtag_host i_jsd_jtag_host (.tap_pins(tap_pins), .tdo_out(tdo_out),
		.tdo_oe_n(tdo_oe_n));

	initial forever #2.5 pclk = ~pclk;

	// clock pins and core drive wander so the pass-through paths see traffic
	initial forever begin
		repeat (20) @(posedge pclk);
		primary_clock_inputs <= NUM_CLK_PIN'($urandom);
		{core_out, core_oe, core_out_only} <= 9'($urandom);
	end

	function automatic logic [31:0] cap_in(input logic [NUM_IOB-1:0] io,
		input logic [NUM_IN_ONLY-1:0] ino);
		logic [31:0] v;
		v = '0;
		for (int i = 0; i < NUM_IOB; i++) v[BIT_IOB_BASE + 3 * i + OFS_IN] = io[i];
		v[BIT_IN_ONLY] = ino[0];
		return v;
	endfunction : cap_in

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) begin
			failures++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	initial begin
		void'($urandom(32'h8734158f));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0, q, err);
		chk({q[CTRL_KEEP_BIT], err}, {CTRL_KEEP_RST, 1'b0});
		apb(1'b0, ADDR_STATUS, 32'h0, q, err);
		chk({q[9:8], q[6:4]}, 5'b10111);
		apb(1'b1, 12'h00c, 32'hffffffff, q, err);
		chk({err, q}, {1'b1, 32'h0});
		$display("register test done");
		i_jsd_jtag_host.tap_reset();
		for (int k = 0; k < 8; k++) begin
			i_jsd_jtag_host.load_ir(k[2:0], cap);
			chk(cap, IR_CAPTURE);
			apb(1'b0, ADDR_STATUS, 32'h0, q, err);
			chk(q[6:4], k[2:0]);
			chk({user_select_one, user_select_two}, {k == 2, k == 3});
		end
		$display("decode test done");
		for (int k = 6; k < 8; k++) begin
			i_jsd_jtag_host.load_ir(k[2:0], cap);
			d = $urandom;
			i_jsd_jtag_host.scan_dr(d, 8, q);
			chk(q[7:1], d[6:0]);
		end
		$display("bypass test done");
		@(posedge pclk);
		io_in <= NUM_IOB'($urandom);
		in_only_pin <= NUM_IN_ONLY'($urandom);
		repeat (4) @(posedge pclk);
		i_jsd_jtag_host.load_ir(INS_SAMPLE, cap);
		d = $urandom;
		i_jsd_jtag_host.scan_dr(d, CHAIN_LEN + 8, q);
		p = cap_in('1, '1) | (32'h1 << BIT_UPD) | (32'h1 << BIT_TDO_EN);
		chk(q & p, cap_in(io_in, in_only_pin));
		chk(q >> CHAIN_LEN, d[7:0]);
		p = d >> 8;
		i_jsd_jtag_host.load_ir(INS_EXTEST, cap);
		repeat (4) @(posedge pclk);
		for (int i = 0; i < NUM_IOB; i++) chk(io_out[i], p[BIT_IOB_BASE + 3 * i + OFS_OUT]);
		chk(out_only_pin, p[BIT_OUT_ONLY]);
		chk({io_oe_n[IOB_TMS], io_oe_n[IOB_TCK], io_oe_n[IOB_TDI]}, 3'b111);
		io_in <= ~io_in;
		repeat (4) @(posedge pclk);
		i_jsd_jtag_host.scan_dr(32'h0, CHAIN_LEN, q);
		chk(q & cap_in('1, '1), cap_in(io_in, in_only_pin));
		$display("boundary test done");
		for (int k = 2; k < 6; k++) begin
			@(posedge pclk);
			{user_scan_out_one, user_scan_out_two, readback_data, config_dout} <= 4'h8 >> (k - 2);
			i_jsd_jtag_host.load_ir(k[2:0], cap);
			i_jsd_jtag_host.scan_dr($urandom, 4, q);
			chk(q[3:0], 4'hf);
		end
		chk(io_oe_n, {NUM_IOB{1'b1}});
		$display("source test done");
		@(posedge pclk);
		config_done <= 1'b1;
		repeat (4) @(posedge pclk);
		i_jsd_jtag_host.load_ir(INS_USER_SCAN_INSTR_ONE, cap);
		chk({user_select_one, pin_pull_up, tdo_oe_n}, 3'b001);
		apb(1'b0, ADDR_STATUS, 32'h0, q, err);
		chk({q[9:8], q[6:4]}, 5'b01111);
		apb(1'b1, ADDR_CTRL, 32'h1, q, err);
		i_jsd_jtag_host.tap_reset();
		i_jsd_jtag_host.load_ir(INS_USER_SCAN_INSTR_TWO, cap);
		repeat (4) @(posedge pclk);
		chk(user_select_two, 1'b1);
		chk({io_oe_n[IOB_TMS], io_oe_n[IOB_TCK], io_oe_n[IOB_TDI]}, 3'b111);
		i_jsd_jtag_host.load_ir(INS_CONFIGURE, cap);
		repeat (4) @(posedge pclk);
		chk(io_oe_n, {NUM_IOB{1'b1}});
		$display("config test done");
		tally_and_finish();
	end
endmodule : jsd_top_tb_top
